/* File: pkg/fwos_regs.svh */
// register map, field positions and timing counts of the status poller
`ifndef FWOS_REGS_SVH
`define FWOS_REGS_SVH
`define FWOS_OFS_CMD        4'h0
`define FWOS_OFS_CFG        4'h1
`define FWOS_OFS_ADDR       4'h2
`define FWOS_OFS_WDATA      4'h3
`define FWOS_OFS_STATUS     4'h4
`define FWOS_OFS_RDATA      4'h5
`define FWOS_CMD_WRITE      0
`define FWOS_CMD_READ       1
`define FWOS_CMD_POLL       2
`define FWOS_CMD_TIMER      3
`define FWOS_CFG_CE_FRAME   0
`define FWOS_ST_BUSY        0
`define FWOS_ST_DONE        1
`define FWOS_ST_FAIL        2
`define FWOS_ST_TIMER       3
`define FWOS_ST_LIMIT       4
`define FWOS_BIT_TOGGLE     6
`define FWOS_BIT_LIMIT      5
`define FWOS_BIT_TIMER      3
`define FWOS_RESET_CMD      8'hF0
`define FWOS_CFG_RESET      32'h0000_0000
`define FWOS_CLK_MHZ        100
`define FWOS_T_STROBE_NS    80
`define FWOS_T_RECOV_NS     30
`define FWOS_STROBE_CYC ((`FWOS_T_STROBE_NS*`FWOS_CLK_MHZ+999)/1000)
`define FWOS_RECOV_CYC  ((`FWOS_T_RECOV_NS*`FWOS_CLK_MHZ+999)/1000)
`endif

/* File: pkg/fwos_pkg.sv */
// types shared by the status poller modules
package fwos_pkg;
  typedef enum logic [3:0] {
    FWOS_IDLE  = 4'b0000,
    FWOS_WR    = 4'b0001,
    FWOS_RD    = 4'b0010,
    FWOS_P_RD1 = 4'b0011,
    FWOS_P_RD2 = 4'b0100,
    FWOS_P_RD3 = 4'b0101,
    FWOS_P_RD4 = 4'b0110,
    FWOS_P_RST = 4'b0111,
    FWOS_TMR   = 4'b1000
  } fwos_state_e;
  typedef enum logic [1:0] {
    FWOS_E_IDLE   = 2'b00,
    FWOS_E_STROBE = 2'b01,
    FWOS_E_RECOV  = 2'b10
  } fwos_eng_e;
  typedef logic [7:0] fwos_byte_t;
endpackage

/* File: pkg/fwos_bus_if.sv */
// request and answer between the poll sequencer and the bus cycle engine
interface fwos_bus_if #(parameter int AW = 21);
  logic                 go;
  logic                 is_write;
  logic                 use_ce;
  logic [AW-1:0]        addr;
  fwos_pkg::fwos_byte_t wdata;
  logic                 done;
  fwos_pkg::fwos_byte_t rdata;
  modport ctl (output go, is_write, use_ce, addr, wdata,
               input done, rdata);
  modport eng (input go, is_write, use_ce, addr, wdata,
               output done, rdata);
endinterface

/* File: rtl/fwos_engine.sv */
// one asynchronous flash bus cycle: command write or framed read
`include "fwos_regs.svh"
module fwos_engine #(
  parameter int AW = 21
) (
  input  wire logic            sys_clk_in,
  input  wire logic            rst_in,
  fwos_bus_if.eng              bus,
  output logic                 ce_n_out,
  output logic                 oe_n_out,
  output logic                 we_n_out,
  output logic [AW-1:0]        addr_out,
  output logic [7:0]           dq_out,
  output logic                 dq_oe_n_out,
  input  wire logic [7:0]      dq_in
);
  import fwos_pkg::*;
  localparam logic [7:0] STROBE = 8'(`FWOS_STROBE_CYC);
  localparam logic [7:0] RECOV  = 8'(`FWOS_RECOV_CYC);

  fwos_eng_e   st_q;
  logic [7:0]  cnt_q;
  logic [7:0]  s1_q, s2_q, s3_q;
  logic        wr_q;

  // data pins cross three flops; a value counts once stages 2 and 3 agree
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
    end else begin
      s1_q <= dq_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // strobe then recovery; a read ends only on a settled sample
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q        <= FWOS_E_IDLE;
      cnt_q       <= 8'h00;
      wr_q        <= 1'b0;
      ce_n_out    <= 1'b1;
      oe_n_out    <= 1'b1;
      we_n_out    <= 1'b1;
      addr_out    <= '0;
      dq_out      <= 8'h00;
      dq_oe_n_out <= 1'b1;
      bus.done    <= 1'b0;
      bus.rdata   <= 8'h00;
    end else begin
      bus.done <= 1'b0;
      case (st_q)
        FWOS_E_IDLE: begin
          // ce framing parks oe low so ce alone delimits each read
          oe_n_out <= ~bus.use_ce;
          if (bus.go) begin
            st_q        <= FWOS_E_STROBE;
            // ce framing parks oe low: a write holds ce high for one cycle
            // so oe is up before ce falls and the device never drives dq
            cnt_q       <= (bus.is_write && bus.use_ce) ? STROBE + 8'h01
                                                        : STROBE;
            wr_q        <= bus.is_write;
            addr_out    <= bus.addr;
            dq_out      <= bus.wdata;
            dq_oe_n_out <= ~bus.is_write;
            ce_n_out    <= bus.is_write & bus.use_ce;
            we_n_out    <= ~bus.is_write;
            oe_n_out    <= bus.is_write | bus.use_ce ? bus.is_write : 1'b0;
          end
        end
        FWOS_E_STROBE: begin
          if (cnt_q > 8'h01) begin
            cnt_q    <= cnt_q - 8'h01;
            ce_n_out <= 1'b0;
          end else if (wr_q || s2_q == s3_q) begin
            // releasing the strobe completes the cycle for the device
            st_q      <= FWOS_E_RECOV;
            cnt_q     <= RECOV;
            ce_n_out  <= 1'b1;
            we_n_out  <= 1'b1;
            oe_n_out  <= wr_q | ~bus.use_ce;
            bus.rdata <= s3_q;
          end
        end
        FWOS_E_RECOV: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            st_q        <= FWOS_E_IDLE;
            dq_oe_n_out <= 1'b1;
            bus.done    <= 1'b1;
          end
        end
        default: st_q <= FWOS_E_IDLE;
      endcase
    end
  end

  AST_NO_CONTENTION: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !(!oe_n_out && !we_n_out))
    else $error("read and write strobes low together");
endmodule

/* File: rtl/fwos_top.sv */
// flash status poller: axi4-lite registers, toggle-check sequencer
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`include "fwos_regs.svh"
module fwos_top #(
  parameter int AW = 21
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 s_axi_awvalid_in,
  output logic                      s_axi_awready_out,
  input  wire logic [5:0]           s_axi_awaddr_in,
  input  wire logic                 s_axi_wvalid_in,
  output logic                      s_axi_wready_out,
  input  wire logic [31:0]          s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  output logic                      s_axi_bvalid_out,
  input  wire logic                 s_axi_bready_in,
  output logic [1:0]                s_axi_bresp_out,
  input  wire logic                 s_axi_arvalid_in,
  output logic                      s_axi_arready_out,
  input  wire logic [5:0]           s_axi_araddr_in,
  output logic                      s_axi_rvalid_out,
  input  wire logic                 s_axi_rready_in,
  output logic [31:0]               s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  output logic                      flash_ce_n_out,
  output logic                      flash_oe_n_out,
  output logic                      flash_we_n_out,
  output logic [AW-1:0]             flash_addr_out,
  output logic [7:0]                flash_dq_out,
  output logic                      flash_dq_oe_n_out,
  input  wire logic [7:0]           flash_dq_in
);
  import fwos_pkg::*;

  fwos_bus_if #(.AW(AW)) bus ();
  fwos_state_e    st_q;
  logic [AW-1:0]  addr_q;
  fwos_byte_t     wdata_q, rdata_q, first_q;
  logic           ce_frame_q, done_q, fail_q, timer_q, limit_q;
  logic           aw_got_q, w_got_q;
  logic [3:0]     aw_idx_q;
  logic [31:0]    w_data_q;
  logic [3:0]     w_strb_q;
  logic           go_q;
  logic [3:0]     cmd_q;
  logic           cmd_pulse_q;

  // register index from a byte address; unmapped above the last one
  function automatic logic mapped(input logic [3:0] idx);
    mapped = idx <= `FWOS_OFS_RDATA;
  endfunction

  fwos_engine #(.AW(AW)) u_engine (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .bus         (bus.eng),
    .ce_n_out    (flash_ce_n_out),
    .oe_n_out    (flash_oe_n_out),
    .we_n_out    (flash_we_n_out),
    .addr_out    (flash_addr_out),
    .dq_out      (flash_dq_out),
    .dq_oe_n_out (flash_dq_oe_n_out),
    .dq_in       (flash_dq_in)
  );

  assign bus.go       = go_q;
  assign bus.use_ce   = ce_frame_q;
  assign bus.addr     = addr_q;
  assign bus.is_write = (st_q == FWOS_WR) || (st_q == FWOS_P_RST);
  assign bus.wdata    = (st_q == FWOS_P_RST) ? `FWOS_RESET_CMD : wdata_q;

  // address and data are taken in either order, response after both
  assign s_axi_awready_out = !aw_got_q && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_got_q && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  // write channel capture and register update
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_got_q         <= 1'b0;
      w_got_q          <= 1'b0;
      aw_idx_q         <= 4'h0;
      w_data_q         <= 32'h0000_0000;
      w_strb_q         <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= 2'b00;
      ce_frame_q       <= 1'(`FWOS_CFG_RESET);
      addr_q           <= '0;
      wdata_q          <= 8'h00;
      cmd_q            <= 4'h0;
      cmd_pulse_q      <= 1'b0;
    end else begin
      cmd_pulse_q <= 1'b0;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr_in[5:2];
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (aw_got_q && w_got_q) begin
        aw_got_q         <= 1'b0;
        w_got_q          <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= mapped(aw_idx_q) ? 2'b00 : 2'b10;
        if (w_strb_q[0]) begin
          case (aw_idx_q)
            `FWOS_OFS_CMD: begin
              cmd_q       <= w_data_q[3:0];
              cmd_pulse_q <= 1'b1;
            end
            `FWOS_OFS_CFG:   ce_frame_q <= w_data_q[`FWOS_CFG_CE_FRAME];
            `FWOS_OFS_ADDR:  addr_q     <= w_data_q[AW-1:0];
            `FWOS_OFS_WDATA: wdata_q    <= w_data_q[7:0];
            default: ;
          endcase
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= 2'b00;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= mapped(s_axi_araddr_in[5:2]) ? 2'b00 : 2'b10;
      case (s_axi_araddr_in[5:2])
        `FWOS_OFS_CFG:    s_axi_rdata_out <= {31'h0, ce_frame_q};
        `FWOS_OFS_ADDR:   s_axi_rdata_out <= 32'(addr_q);
        `FWOS_OFS_WDATA:  s_axi_rdata_out <= {24'h0, wdata_q};
        `FWOS_OFS_STATUS: s_axi_rdata_out <= {27'h0, limit_q, timer_q,
                                             fail_q, done_q,
                                             st_q != FWOS_IDLE};
        `FWOS_OFS_RDATA:  s_axi_rdata_out <= {24'h0, rdata_q};
        default:          s_axi_rdata_out <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // sequencer: a command written while busy is dropped, not queued
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q    <= FWOS_IDLE;
      go_q    <= 1'b0;
      first_q <= 8'h00;
      rdata_q <= 8'h00;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
      timer_q <= 1'b0;
      limit_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      case (st_q)
        FWOS_IDLE: begin
          if (cmd_pulse_q && cmd_q != 4'h0) begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            go_q   <= 1'b1;
            if (cmd_q[`FWOS_CMD_WRITE])      st_q <= FWOS_WR;
            else if (cmd_q[`FWOS_CMD_READ])  st_q <= FWOS_RD;
            else if (cmd_q[`FWOS_CMD_POLL])  st_q <= FWOS_P_RD1;
            // the timer check is optional: fast software may skip it
            else                             st_q <= FWOS_TMR;
          end
        end
        FWOS_WR, FWOS_RD: begin
          if (bus.done) begin
            rdata_q <= bus.rdata;
            done_q  <= 1'b1;
            st_q    <= FWOS_IDLE;
          end
        end
        FWOS_TMR: begin
          // a one here after an added sector may mean it was refused
          if (bus.done) begin
            rdata_q <= bus.rdata;
            timer_q <= bus.rdata[`FWOS_BIT_TIMER];
            done_q  <= 1'b1;
            st_q    <= FWOS_IDLE;
          end
        end
        FWOS_P_RD1, FWOS_P_RD3: begin
          if (bus.done) begin
            first_q <= bus.rdata;
            go_q    <= 1'b1;
            st_q    <= (st_q == FWOS_P_RD1) ? FWOS_P_RD2 : FWOS_P_RD4;
          end
        end
        FWOS_P_RD2: begin
          if (bus.done) begin
            rdata_q <= bus.rdata;
            limit_q <= bus.rdata[`FWOS_BIT_LIMIT];
            if (bus.rdata[`FWOS_BIT_TOGGLE] == first_q[`FWOS_BIT_TOGGLE]) begin
              done_q <= 1'b1;
              st_q   <= FWOS_IDLE;
            end else if (bus.rdata[`FWOS_BIT_LIMIT]) begin
              go_q <= 1'b1;
              st_q <= FWOS_P_RD3;
            end else begin
              // every new look starts again with a fresh pair of reads
              go_q <= 1'b1;
              st_q <= FWOS_P_RD1;
            end
          end
        end
        FWOS_P_RD4: begin
          if (bus.done) begin
            rdata_q <= bus.rdata;
            if (bus.rdata[`FWOS_BIT_TOGGLE] == first_q[`FWOS_BIT_TOGGLE]) begin
              done_q <= 1'b1;
              st_q   <= FWOS_IDLE;
            end else begin
              go_q <= 1'b1;
              st_q <= FWOS_P_RST;
            end
          end
        end
        FWOS_P_RST: begin
          if (bus.done) begin
            fail_q <= 1'b1;
            done_q <= 1'b1;
            st_q   <= FWOS_IDLE;
          end
        end
        default: st_q <= FWOS_IDLE;
      endcase
    end
  end

  AST_PAIR_READS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == FWOS_P_RD2 && $past(st_q) != FWOS_P_RD2
      |-> $past(st_q) == FWOS_P_RD1)
    else $error("compare read not preceded by first read");
  AST_STEADY_DONE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == FWOS_P_RD2 && bus.done
      && bus.rdata[6] == first_q[6] |=> st_q == FWOS_IDLE && done_q)
    else $error("steady toggle bit did not end polling");
  AST_LIMIT_RECHECK: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == FWOS_P_RD2 && bus.done && bus.rdata[6] != first_q[6]
      && bus.rdata[5] |=> st_q == FWOS_P_RD3 && go_q)
    else $error("limit flag high but no recheck");
  AST_RESTART: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == FWOS_P_RD2 && bus.done && bus.rdata[6] != first_q[6]
      && !bus.rdata[5] |=> st_q == FWOS_P_RD1)
    else $error("polling resumed without a fresh read pair");
  AST_RESET_BYTE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == FWOS_P_RST && !flash_we_n_out
      |-> flash_dq_out == 8'hF0 && !flash_dq_oe_n_out)
    else $error("reset command byte wrong on the pins");
  AST_RESET_CAUSE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == FWOS_P_RST && $past(st_q) != FWOS_P_RST
      |-> $past(st_q) == FWOS_P_RD4 && limit_q)
    else $error("reset issued without limit flag and toggling");
  AST_TIMER_BIT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == FWOS_TMR && bus.done |=> timer_q == $past(bus.rdata[3]))
    else $error("erase timer result differs from read bit");
  AST_CE_FRAME: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_frame_q && st_q == FWOS_RD && !flash_ce_n_out
      |-> !flash_oe_n_out)
    else $error("ce framed read without output enable");

  COV_POLL_OK: cover property (@(posedge sys_clk_in)
    st_q == FWOS_P_RD2 ##1 st_q == FWOS_IDLE && done_q && !fail_q);
  COV_POLL_FAIL: cover property (@(posedge sys_clk_in)
    st_q == FWOS_P_RST ##1 st_q == FWOS_IDLE && fail_q);
  COV_TIMER: cover property (@(posedge sys_clk_in)
    st_q == FWOS_TMR ##1 st_q == FWOS_IDLE && timer_q);
endmodule

/* File: test/fwos_flash_model.sv */
// behavioural flash device: toggle status bits and reset command
module fwos_flash_model #(
  parameter logic [7:0] ERASE_BYTE = 8'hE0
) (
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [20:0] addr_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic        load_in,
  input  wire logic [7:0]  left_in,
  input  wire logic        limit_in,
  input  wire logic        timer_in,
  input  wire logic [7:0]  array_in,
  input  wire logic [8:0]  esec_in,
  output logic [7:0]       dq_out,
  output logic [20:0]      wr_addr_out,
  output logic [7:0]       wr_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time WIN = 50us;
  logic [7:0] left_q = 8'h00;
  logic       win_q    = 1'b0;
  logic       win_done = 1'b0;
  time        win_end  = 0;
  wire        tmr = win_q ? win_done : timer_in;
  logic       tog_q  = 1'b0;
  logic       stog_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic [7:0] cur;
  wire        rd = !ce_n_in && !oe_n_in && we_n_in;
  wire        wr = !ce_n_in && !we_n_in;
  // status byte while an algorithm runs, array data once it is over
  assign cur = (left_q != 8'h00) ? {~array_in[7], tog_q, limit_in, 1'b0,
               tmr, stog_q, 2'b00} : array_in;
  // a released bus shows the inverse of the last byte, never a stale copy
  assign dq_out = rd ? cur : ~last_q;
  // toggling reads left: short for protected sectors, zero in suspend
  always @(posedge load_in) left_q = left_in;
  // the erase window closes once its full length has run out
  always begin
    #100ns;
    win_done = win_q && ($time >= win_end);
  end
  // advance the toggle bits once per completed read while an algorithm runs: bit 6 at any address, bit 2 only inside the erasing sector
  always @(negedge rd) begin
    last_q = cur;
    if (left_q != 8'h00) begin
      tog_q  = ~tog_q;
      if (addr_in[20:12] == esec_in) stog_q = ~stog_q;
      left_q = left_q - 8'h01;
    end
  end
  // the reset command ends a failed algorithm and restores array reads
  always @(negedge wr) begin
    wr_addr_out = addr_in;
    wr_data_out = dq_in;
    if (dq_in == 8'hF0) left_q = 8'h00;
    // an added erase restarts the window; after it closes it is refused
    if (dq_in == ERASE_BYTE && !win_done) begin
      win_q    = 1'b1;
      win_done = 1'b0;
      win_end  = $time + WIN;
    end
  end
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the flash status poller
`include "fwos_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_in, rst_in, load, limit, timer;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        ce_n, oe_n, we_n, dq_oe_n;
  logic [20:0] faddr, wr_addr;
  logic [7:0]  dq_o, dq_i, wr_data, left, arr;
  int          miscompares = 0;
  int          comparisons = 0;
  int          seed = 32'h553D;
  localparam logic [7:0] ERASE = 8'hE0; // erase byte known to the model

  fwos_top DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .flash_ce_n_out(ce_n),
    .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
    .flash_addr_out(faddr), .flash_dq_out(dq_o),
    .flash_dq_oe_n_out(dq_oe_n), .flash_dq_in(dq_i));

  fwos_flash_model #(.ERASE_BYTE(ERASE)) MODEL (.ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(faddr), .dq_in(dq_o), .load_in(load), .left_in(left),
    .limit_in(limit), .timer_in(timer), .array_in(arr),
    .esec_in(9'h000), .dq_out(dq_i), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data));

  // free-running system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("BAD %0t no answer in %s", $time, what);
    final_report();
  endtask

  // ready is sampled mid-cycle: it is settled there and holds to the edge
  task automatic axi_wr(input logic [3:0] idx, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_t, w_t, b_t;
    int   n;
    @(posedge sys_clk_in);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_t = 1'b0;
    for (n = 0; n < 100 && !b_t; n++) begin
      @(negedge sys_clk_in);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid;
      r    = bresp;
      @(posedge sys_clk_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    if (!b_t) hang("write");
  endtask

  task automatic axi_rd(input logic [3:0] idx, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_t, r_t;
    int   n;
    @(posedge sys_clk_in);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_t = 1'b0;
    for (n = 0; n < 100 && !r_t; n++) begin
      @(negedge sys_clk_in);
      ar_t = arvalid && arready;
      r_t  = rvalid;
      d    = rdata;
      r    = rresp;
      @(posedge sys_clk_in);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    if (!r_t) hang("read");
  endtask

  // the sequencer picks a command up on the edge after the response is raised
  task automatic cmd(input int b, output logic [31:0] st);
    logic [1:0] r;
    int         n;
    axi_wr(`FWOS_OFS_CMD, 32'h1 << b, r);
    repeat (4) @(posedge sys_clk_in);
    st = 32'h1;
    for (n = 0; n < 400 && st[`FWOS_ST_BUSY] !== 1'b0; n++)
      axi_rd(`FWOS_OFS_STATUS, st, r);
    if (st[`FWOS_ST_BUSY] !== 1'b0) hang("busy");
  endtask

  task automatic set_dev(input logic [7:0] n, input logic l, input logic t);
    @(posedge sys_clk_in);
    left  <= n;
    limit <= l;
    timer <= t;
    arr   <= 8'($random(seed));
    @(posedge sys_clk_in);
    load <= 1'b1;
    @(posedge sys_clk_in);
    load <= 1'b0;
  endtask

  // expected busy/done/fail bits after a poll; done is not judged on fail
  function automatic logic [31:0] poll_exp(input logic failed);
    return failed ? 32'h4 : 32'h2;
  endfunction

  function automatic logic [31:0] poll_mask(input logic failed);
    return failed ? 32'h5 : 32'h7;
  endfunction

  initial begin
    logic [31:0] d, d2, st;
    logic [1:0]  r;
    logic        t;
    int          k;
    rst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, load} = 6'h00;
    {awaddr, araddr, wdata} = 44'h0;
    {left, arr, limit, timer} = 18'h0;
    repeat (4) @(posedge sys_clk_in);
    check(32'({ce_n, oe_n, we_n, dq_oe_n}), 32'hF, "reset strobes");
    rst_in <= 1'b0;
    axi_rd(`FWOS_OFS_CFG, d, r);
    check(d, `FWOS_CFG_RESET, "cfg reset");
    axi_rd(4'h6, d, r);
    check(32'(r), 32'h2, "unmapped read resp");
    check(d, 32'h0, "unmapped read data");
    axi_wr(4'h7, 32'hFFFF_FFFF, r);
    check(32'(r), 32'h2, "unmapped write resp");
    $display("test reset and map done");
    // plain write cycle with random address and the fixed byte 5A
    d = 32'($random(seed)) & 32'h1F_FFFF;
    axi_wr(`FWOS_OFS_ADDR, d, r);
    axi_wr(`FWOS_OFS_WDATA, 32'h5A, r);
    cmd(`FWOS_CMD_WRITE, st);
    check(32'(wr_addr), d, "write address");
    check(32'(wr_data), 32'h5A, "write data");
    $display("test write done");
    // both framings, random toggle lengths, addresses inside the sector
    for (k = 0; k < 6; k++) begin
      t = 1'($random(seed));
      axi_wr(`FWOS_OFS_CFG, 32'(k % 2), r);
      axi_wr(`FWOS_OFS_ADDR, 32'($random(seed)) & 32'hFFF, r);
      set_dev(8'(3 + ($random(seed) & 3)), 1'b0, t);
      cmd(`FWOS_CMD_TIMER, st);
      check(32'(st[`FWOS_ST_TIMER]), 32'(t), "timer flag");
      cmd(`FWOS_CMD_READ, st);
      axi_rd(`FWOS_OFS_RDATA, d, r);
      cmd(`FWOS_CMD_READ, st);
      axi_rd(`FWOS_OFS_RDATA, d2, r);
      check(32'(d[6] ^ d2[6]), 32'h1, "toggle bit");
      check(32'(d[2] ^ d2[2]), 32'h1, "sector toggle");
      cmd(`FWOS_CMD_POLL, st);
      check(st & poll_mask(0), poll_exp(0), "poll status");
      axi_rd(`FWOS_OFS_RDATA, d, r);
      check(d & 32'hFF, 32'(arr), "array after poll");
      $display("test poll %0d done", k);
    end
    // limit flag up and still toggling: reset command and failure
    set_dev(8'hFF, 1'b1, 1'b0);
    cmd(`FWOS_CMD_POLL, st);
    check(st & poll_mask(1), poll_exp(1), "limit fail");
    check(32'(st[`FWOS_ST_LIMIT]), 32'h1, "limit seen");
    check(32'(wr_data), 32'(`FWOS_RESET_CMD), "reset cmd");
    cmd(`FWOS_CMD_READ, st);
    axi_rd(`FWOS_OFS_RDATA, d, r);
    check(d & 32'hFF, 32'(arr), "array after reset");
    $display("test limit fail done");
    // limit flag up but toggling stops at the recheck: success
    set_dev(8'h02, 1'b1, 1'b0);
    cmd(`FWOS_CMD_POLL, st);
    check(st & poll_mask(0), poll_exp(0), "late stop");
    $display("test late stop done");
    // erase window: an added erase restarts it, a late one is refused
    set_dev(8'hFF, 1'b0, 1'b0);
    axi_wr(`FWOS_OFS_WDATA, 32'(ERASE), r);
    for (k = 0; k < 4; k++) begin
      if (k != 2) cmd(`FWOS_CMD_WRITE, st);
      cmd(`FWOS_CMD_TIMER, st);
      check(32'(st[`FWOS_ST_TIMER]), 32'(k == 3), "erase timer");
      repeat (3000) @(posedge sys_clk_in);
    end
    $display("test erase window done");
    final_report();
  end
endmodule
